// *** imle_pkg.sv ***
// Package with encodings and constants of the indirect move / literal unit
package imle_pkg;
  // Instruction classes presented by the decoder
  localparam logic [2:0] IMLE_OP_NONE = 3'h0;
  localparam logic [2:0] IMLE_OP_MOVE_INDIRECT = 3'h1;
  localparam logic [2:0] IMLE_OP_MOVE_RELATIVE = 3'h2;
  localparam logic [2:0] IMLE_OP_LOAD_BANK = 3'h3;
  localparam logic [2:0] IMLE_OP_LOAD_LATCH = 3'h4;
  localparam logic [2:0] IMLE_OP_LOAD_WORK = 3'h5;
  // Pointer update modes
  localparam logic [1:0] IMLE_MODE_PRE_INC = 2'h0;
  localparam logic [1:0] IMLE_MODE_PRE_DEC = 2'h1;
  localparam logic [1:0] IMLE_MODE_POST_INC = 2'h2;
  localparam logic [1:0] IMLE_MODE_POST_DEC = 2'h3;
  // Widths
  localparam int IMLE_PTR_W = 16;
  localparam int IMLE_BANK_W = 6;
  localparam int IMLE_LATCH_W = 7;
  localparam int IMLE_OFFS_W = 6;
  // Reset values
  localparam logic [15:0] IMLE_PTR_RST = 16'h0000;
  localparam logic [7:0] IMLE_WORK_RST = 8'h00;
  localparam logic [5:0] IMLE_BANK_RST = 6'h00;
  localparam logic [6:0] IMLE_LATCH_RST = 7'h00;
  // State codes, one-hot
  typedef enum logic [1:0] {
    IMLE_ST_IDLE = 2'b01,
    IMLE_ST_READ = 2'b10
  } imle_state_t;
endpackage

// *** imle_ptr_file.sv ***
// Two-entry pointer register store with registered read data
`timescale 1ns/1ps
module imle_ptr_file
  import imle_pkg::*;
#(
  parameter int WIDTH = IMLE_PTR_W
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic wr_en_i,
  input wire logic wr_sel_i,
  input wire logic [WIDTH-1:0] wr_data_i,
  output logic [WIDTH-1:0] ptr0_o,
  output logic [WIDTH-1:0] ptr1_o
);
  // Both entries are held in flops, read data is the flop itself
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ptr0_o <= IMLE_PTR_RST;
      ptr1_o <= IMLE_PTR_RST;
    end else if (ce_i && wr_en_i) begin
      // Selected entry only
      if (wr_sel_i) begin
        ptr1_o <= wr_data_i;
      end else begin
        ptr0_o <= wr_data_i;
      end
    end
  end
endmodule // imle_ptr_file

// *** imle_exec.sv ***
// Execution unit for indirect moves and literal loads
//
// Summary of operation
// RL1 - Indirect move reads selected pointer's target into W
// RL2 - Indirect port has no storage, redirected
// RL3 - Mode field selects pre/post increment/decrement
// RL4 - Pre modes use new pointer; post old
// RL5 - Relative form adds signed offset; pointer unchanged
// RL6 - Sixteen-bit pointer wraps modulo range
// RL7 - Indirect move sets zero flag from data
// RL8 - Bank literal loads six-bit bank register
// RL9 - Latch literal loads seven-bit latch register
// RL10 - Work literal loads W, flags untouched
`timescale 1ns/1ps
module imle_exec
  import imle_pkg::*;
#(
  parameter int PTR_W = IMLE_PTR_W
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic op_valid_i,
  input wire logic [2:0] op_class_i,
  input wire logic ptr_sel_i,
  input wire logic [1:0] pointer_update_mode_i,
  input wire logic [IMLE_OFFS_W-1:0] offset_i,
  input wire logic [7:0] literal_i,
  input wire logic ptr_wr_i,
  input wire logic ptr_wr_sel_i,
  input wire logic [PTR_W-1:0] ptr_wr_data_i,
  input wire logic [7:0] mem_rdata_i,
  output logic busy_o,
  output logic mem_rd_o,
  output logic [PTR_W-1:0] mem_addr_o,
  output logic [7:0] work_o,
  output logic work_wr_o,
  output logic zero_flag_o,
  output logic zero_wr_o,
  output logic [IMLE_BANK_W-1:0] bank_select_reg_o,
  output logic [IMLE_LATCH_W-1:0] program_counter_latch_high_o,
  output logic [PTR_W-1:0] ptr0_o,
  output logic [PTR_W-1:0] ptr1_o
);
  // Sign-extend the six-bit relative offset to pointer width
  function automatic logic [PTR_W-1:0] sext_offs(
    input logic [IMLE_OFFS_W-1:0] k
  );
    sext_offs = {{(PTR_W-IMLE_OFFS_W){k[IMLE_OFFS_W-1]}}, k};
  endfunction

  imle_state_t state; // Sequencer state
  logic [PTR_W-1:0] cur_ptr; // Pointer picked by the index
  logic [PTR_W-1:0] ptr_inc; // Pointer plus one, wraps
  logic [PTR_W-1:0] ptr_dec; // Pointer minus one, wraps
  logic [PTR_W-1:0] next_addr; // Effective address
  logic [PTR_W-1:0] next_ptr; // Updated pointer value
  logic upd_ptr; // Pointer write from the move
  logic start_ind; // Indirect move accepted
  logic start_rel; // Relative move accepted
  logic core_wr; // Final pointer write enable
  logic core_sel; // Final pointer write index
  logic [PTR_W-1:0] core_data; // Final pointer write data

  // RL1 pick the pointer
  assign cur_ptr = ptr_sel_i ? ptr1_o : ptr0_o;
  // RL6 wrapping arithmetic
  // Carry out of the top bit is dropped, so it wraps
  assign ptr_inc = cur_ptr + 16'h0001;
  assign ptr_dec = cur_ptr - 16'h0001;

  // Accept only from idle; an op offered while busy is dropped
  // The core sees the drop only through busy_o
  assign start_ind = op_valid_i && (state == IMLE_ST_IDLE) &&
                     (op_class_i == IMLE_OP_MOVE_INDIRECT);
  assign start_rel = op_valid_i && (state == IMLE_ST_IDLE) &&
                     (op_class_i == IMLE_OP_MOVE_RELATIVE);

  // Address and pointer update from the mode field
  always_comb begin
    // Defaults keep the pointer when no move is taken
    next_addr = cur_ptr;
    next_ptr = cur_ptr;
    upd_ptr = 1'b0;
    if (start_rel) begin
      // RL5 offset address, pointer kept
      next_addr = cur_ptr + sext_offs(offset_i);
    end else if (start_ind) begin
      upd_ptr = 1'b1;
      // RL3 mode decode
      case (pointer_update_mode_i)
        IMLE_MODE_PRE_INC: begin
          // RL4 access uses new value
          next_addr = ptr_inc;
          next_ptr = ptr_inc;
        end
        IMLE_MODE_PRE_DEC: begin
          // Access at the stepped value
          next_addr = ptr_dec;
          next_ptr = ptr_dec;
        end
        IMLE_MODE_POST_INC: begin
          // RL4 access uses old value
          next_ptr = ptr_inc;
        end
        IMLE_MODE_POST_DEC: begin
          // Access at the old value
          next_ptr = ptr_dec;
        end
        default: begin
          next_ptr = cur_ptr;
        end
      endcase
    end
  end

  // Move update wins over a direct pointer write in the same cycle
  // The dropped direct write must be repeated by the core
  assign core_wr = upd_ptr || ptr_wr_i;
  assign core_sel = upd_ptr ? ptr_sel_i : ptr_wr_sel_i;
  assign core_data = upd_ptr ? next_ptr : ptr_wr_data_i;

  // Pointer storage, a small module whose read data are flops
  // Reads stay stable for the whole access cycle
  imle_ptr_file #(
    .WIDTH(PTR_W)
  ) u_ptr_file (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .wr_en_i(core_wr),
    .wr_sel_i(core_sel),
    .wr_data_i(core_data),
    .ptr0_o(ptr0_o),
    .ptr1_o(ptr1_o)
  );

  // Sequencer: issue read, then capture data next cycle
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state <= IMLE_ST_IDLE;
    end else if (ce_i) begin
      case (state)
        IMLE_ST_IDLE: begin
          if (start_ind || start_rel) begin
            state <= IMLE_ST_READ;
          end
        end
        IMLE_ST_READ: begin
          // Data arrives now, back to idle
          state <= IMLE_ST_IDLE;
        end
        default: begin
          // Stray code, recover to idle
          state <= IMLE_ST_IDLE;
        end
      endcase
    end
  end

  // Memory request; indirect port is only an address, no storage
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      mem_rd_o <= 1'b0;
      mem_addr_o <= IMLE_PTR_RST;
      busy_o <= 1'b0;
    end else if (ce_i) begin
      // Read data are due in the same cycle as the request strobe
      // RL2 redirect to pointed register
      mem_rd_o <= start_ind || start_rel;
      busy_o <= start_ind || start_rel;
      if (start_ind || start_rel) begin
        // Held between reads; only the strobe qualifies it
        mem_addr_o <= next_addr;
      end
    end
  end

  // Working register and zero flag
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      work_o <= IMLE_WORK_RST;
      work_wr_o <= 1'b0;
      zero_flag_o <= 1'b0;
      zero_wr_o <= 1'b0;
    end else if (ce_i) begin
      // Update strobes are single-cycle pulses
      work_wr_o <= 1'b0;
      zero_wr_o <= 1'b0;
      if (state == IMLE_ST_READ) begin
        // RL1 fetched byte to W
        work_o <= mem_rdata_i;
        work_wr_o <= 1'b1;
        // RL7 zero flag only
        zero_flag_o <= (mem_rdata_i == 8'h00);
        zero_wr_o <= 1'b1;
      end else if (op_valid_i && (state == IMLE_ST_IDLE) &&
                   (op_class_i == IMLE_OP_LOAD_WORK)) begin
        // RL10 literal to W, no flags
        // Z keeps its old value here
        work_o <= literal_i;
        work_wr_o <= 1'b1;
      end
    end
  end

  // Bank select and program latch loads, no flags touched
  // Both are refused while a read is pending, like every op
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      bank_select_reg_o <= IMLE_BANK_RST;
      program_counter_latch_high_o <= IMLE_LATCH_RST;
    end else if (ce_i && op_valid_i && (state == IMLE_ST_IDLE)) begin
      if (op_class_i == IMLE_OP_LOAD_BANK) begin
        // RL8 six-bit bank load
        // Literal bits above the field are dropped
        bank_select_reg_o <= literal_i[IMLE_BANK_W-1:0];
      end
      if (op_class_i == IMLE_OP_LOAD_LATCH) begin
        // RL9 seven-bit latch load
        program_counter_latch_high_o <= literal_i[IMLE_LATCH_W-1:0];
      end
    end
  end
endmodule // imle_exec

// *** imle_exec_chk.sv ***
// Assertions on the indirect move and literal load unit
`timescale 1ns/1ps
module imle_chk
  import imle_pkg::*;
#(parameter int PTR_W = 16) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic op_valid_i,
  input wire logic [2:0] op_class_i,
  input wire logic ptr_sel_i,
  input wire logic [1:0] pointer_update_mode_i,
  input wire logic [5:0] offset_i,
  input wire logic [7:0] literal_i,
  input wire logic ptr_wr_i,
  input wire logic [7:0] mem_rdata_i,
  input wire logic busy_o,
  input wire logic mem_rd_o,
  input wire logic [PTR_W-1:0] mem_addr_o,
  input wire logic [7:0] work_o,
  input wire logic work_wr_o,
  input wire logic zero_flag_o,
  input wire logic zero_wr_o,
  input wire logic [5:0] bank_select_reg_o,
  input wire logic [6:0] program_counter_latch_high_o,
  input wire logic [PTR_W-1:0] ptr0_o,
  input wire logic [PTR_W-1:0] ptr1_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // Op taken only while idle
  wire tk = ce_i && op_valid_i && !busy_o;
  wire m1 = tk && op_class_i == IMLE_OP_MOVE_INDIRECT;
  wire m2 = tk && op_class_i == IMLE_OP_MOVE_RELATIVE;
  wire [PTR_W-1:0] sel = ptr_sel_i ? ptr1_o : ptr0_o;
  // Stepped pointer, wraps by width
  wire [PTR_W-1:0] nx = pointer_update_mode_i[0] ? sel - 1'b1 : sel + 1'b1;
  property p_rd; m1 || m2 |=> mem_rd_o && busy_o; endproperty
  a_rd: assert property (p_rd) else $error("no read after move");
  property p_wk;
    mem_rd_o && ce_i |=> work_wr_o && zero_wr_o &&
      work_o == $past(mem_rdata_i);
  endproperty
  a_wk: assert property (p_wk) else $error("bad moved byte");
  property p_z; zero_wr_o |-> zero_flag_o == (work_o == 8'h00); endproperty
  a_z: assert property (p_z) else $error("bad zero flag");
  property p_pre; m1 && !pointer_update_mode_i[1] |=> mem_addr_o == $past(nx);
  endproperty
  a_pre: assert property (p_pre) else $error("bad pre address");
  property p_pst; m1 && pointer_update_mode_i[1] |=> mem_addr_o == $past(sel);
  endproperty
  a_pst: assert property (p_pst) else $error("bad post address");
  property p_up;
    m1 && !ptr_wr_i |=> ($past(ptr_sel_i) ? ptr1_o : ptr0_o) == $past(nx);
  endproperty
  a_up: assert property (p_up) else $error("bad pointer step");
  property p_rel;
    m2 && !ptr_wr_i |=>
      mem_addr_o == $past(sel + {{10{offset_i[5]}}, offset_i})
      && $stable(ptr0_o) && $stable(ptr1_o);
  endproperty
  a_rel: assert property (p_rel) else $error("bad relative access");
  property p_lb; tk && op_class_i == IMLE_OP_LOAD_BANK |=>
    bank_select_reg_o == $past(literal_i[5:0]) && !zero_wr_o; endproperty
  a_lb: assert property (p_lb) else $error("bad bank load");
  property p_lp; tk && op_class_i == IMLE_OP_LOAD_LATCH |=>
    program_counter_latch_high_o == $past(literal_i[6:0]) && !zero_wr_o;
  endproperty
  a_lp: assert property (p_lp) else $error("bad latch load");
  property p_lw; tk && op_class_i == IMLE_OP_LOAD_WORK |=>
    work_o == $past(literal_i) && work_wr_o && !zero_wr_o; endproperty
  a_lw: assert property (p_lw) else $error("bad work load");
  // Enable low holds W, bank, latch, both pointers, address and busy
  property p_ce; !ce_i |=> $stable(work_o) && $stable(bank_select_reg_o)
    && $stable(program_counter_latch_high_o) && $stable(ptr0_o)
    && $stable(ptr1_o) && $stable(mem_addr_o) && $stable(busy_o);
  endproperty
  a_ce: assert property (p_ce) else $error("state moved with enable low");
endmodule // imle_chk
bind imle_exec imle_chk #(
  .PTR_W(PTR_W)
) u_chk (
  .clk_i(clk_i),
  .rst_n_i(rst_n_i),
  .ce_i(ce_i),
  .op_valid_i(op_valid_i),
  .op_class_i(op_class_i),
  .ptr_sel_i(ptr_sel_i),
  .pointer_update_mode_i(pointer_update_mode_i),
  .offset_i(offset_i),
  .literal_i(literal_i),
  .ptr_wr_i(ptr_wr_i),
  .mem_rdata_i(mem_rdata_i),
  .busy_o(busy_o),
  .mem_rd_o(mem_rd_o),
  .mem_addr_o(mem_addr_o),
  .work_o(work_o),
  .work_wr_o(work_wr_o),
  .zero_flag_o(zero_flag_o),
  .zero_wr_o(zero_wr_o),
  .bank_select_reg_o(bank_select_reg_o),
  .program_counter_latch_high_o(program_counter_latch_high_o),
  .ptr0_o(ptr0_o),
  .ptr1_o(ptr1_o)
);

// *** tb_top.sv ***
// Directed testbench for the indirect move and literal load unit
`timescale 1ns/1ps
module tb_top;
  import imle_pkg::*;
  logic clk_i = 0, rst_n_i = 0, ce_i = 1, op_valid_i = 0, ptr_sel_i = 0;
  logic ptr_wr_i = 0, ptr_wr_sel_i = 0, busy_o, mem_rd_o, work_wr_o;
  logic [2:0] op_class_i = 0;
  logic [1:0] pointer_update_mode_i = 0;
  logic [5:0] offset_i = 0, bank_select_reg_o;
  logic [7:0] literal_i = 0, mem_rdata_i = 0, work_o;
  logic [15:0] ptr_wr_data_i = 0, mem_addr_o, ptr0_o, ptr1_o;
  logic zero_flag_o, zero_wr_o;
  logic [6:0] program_counter_latch_high_o;
  int fails = 0, n_compared = 0;
  imle_exec dut (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .op_valid_i(op_valid_i),
    .op_class_i(op_class_i),
    .ptr_sel_i(ptr_sel_i),
    .pointer_update_mode_i(pointer_update_mode_i),
    .offset_i(offset_i),
    .literal_i(literal_i),
    .ptr_wr_i(ptr_wr_i),
    .ptr_wr_sel_i(ptr_wr_sel_i),
    .ptr_wr_data_i(ptr_wr_data_i),
    .mem_rdata_i(mem_rdata_i),
    .busy_o(busy_o),
    .mem_rd_o(mem_rd_o),
    .mem_addr_o(mem_addr_o),
    .work_o(work_o),
    .work_wr_o(work_wr_o),
    .zero_flag_o(zero_flag_o),
    .zero_wr_o(zero_wr_o),
    .bank_select_reg_o(bank_select_reg_o),
    .program_counter_latch_high_o(program_counter_latch_high_o),
    .ptr0_o(ptr0_o),
    .ptr1_o(ptr1_o)
  );
  initial forever #4 clk_i = ~clk_i;
  task automatic chk(input string n, input logic [15:0] s, e);
    n_compared++;
    if (s !== e) begin
      fails++;
      $display("[FAIL] %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic end_of_test();
    if (fails == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Direct pointer write, one cycle
  task automatic wp(input logic s, input logic [15:0] v);
    @(posedge clk_i); #1;
    {ptr_wr_i, ptr_wr_sel_i, ptr_wr_data_i} = {1'b1, s, v};
    @(posedge clk_i); #1;
    ptr_wr_i = 0;
  endtask
  // One move: address at +1, W and Z at +2
  task automatic mv(input logic [2:0] c, input logic s, input logic [1:0] m,
      input logic [5:0] k, input logic [7:0] d, input logic [15:0] ea, ep);
    @(posedge clk_i); #1;
    {op_valid_i, op_class_i, ptr_sel_i} = {1'b1, c, s};
    {pointer_update_mode_i, offset_i} = {m, k};
    @(posedge clk_i); #1;
    {op_valid_i, mem_rdata_i} = {1'b0, d};
    chk("rd", {mem_rd_o, busy_o}, 2'b11);
    chk("addr", mem_addr_o, ea);
    chk("ptr", s ? ptr1_o : ptr0_o, ep);
    @(posedge clk_i); #1;
    mem_rdata_i = ~d;
    chk("work", {work_wr_o, work_o}, {1'b1, d});
    chk("z", {zero_wr_o, zero_flag_o}, {1'b1, d == 8'h00});
  endtask
  task automatic lit(input logic [2:0] c, input logic [7:0] l);
    @(posedge clk_i); #1;
    {op_valid_i, op_class_i, literal_i} = {1'b1, c, l};
    @(posedge clk_i); #1;
    op_valid_i = 0;
  endtask
  // Every mode, both pointers, at the wrap edges
  task automatic t_modes();
    for (int i = 0; i < 4; i++) begin
      wp(i[0], i[0] ? 16'h0000 : 16'hffff);
      mv(IMLE_OP_MOVE_INDIRECT, i[0], i[1:0], 6'h00, 8'h35 * i[7:0],
        i[1] ? {16{~i[0]}} : {16{i[0]}}, {16{i[0]}});
    end
  endtask
  // Offset extremes, pointer left alone
  task automatic t_rel();
    wp(1'b1, 16'h1000);
    mv(IMLE_OP_MOVE_RELATIVE, 1'b1, 2'h0, 6'h20, 8'h81,
      16'h0fe0, 16'h1000);
    mv(IMLE_OP_MOVE_RELATIVE, 1'b1, 2'h3, 6'h1f, 8'h00,
      16'h101f, 16'h1000);
  endtask
  // Literals one idle cycle apart; Z stays set
  task automatic t_lit();
    lit(IMLE_OP_LOAD_WORK, 8'ha5);
    chk("w", {work_wr_o, work_o, zero_wr_o, zero_flag_o},
      {1'b1, 8'ha5, 2'b01});
    lit(IMLE_OP_LOAD_BANK, 8'hff);
    chk("bank", {zero_wr_o, bank_select_reg_o}, {1'b0, 6'h3f});
    lit(IMLE_OP_LOAD_LATCH, 8'hff);
    chk("latch", program_counter_latch_high_o, 7'h7f);
  endtask
  // Enable low freezes a load, which lands once enable returns
  task automatic t_ce();
    @(posedge clk_i); #1;
    {ce_i, op_valid_i} = 2'b01;
    {op_class_i, literal_i} = {IMLE_OP_LOAD_BANK, 8'h15};
    @(posedge clk_i); #1;
    ce_i = 1;
    chk("ce hold", bank_select_reg_o, 6'h3f);
    @(posedge clk_i); #1;
    op_valid_i = 0;
    chk("ce load", bank_select_reg_o, 6'h15);
  endtask
  // A bank load offered while a read is pending is dropped
  task automatic t_busy();
    @(posedge clk_i); #1;
    {op_valid_i, op_class_i} = {1'b1, IMLE_OP_MOVE_RELATIVE};
    {ptr_sel_i, offset_i, literal_i} = {1'b0, 6'h00, 8'h2a};
    @(posedge clk_i); #1;
    op_class_i = IMLE_OP_LOAD_BANK;
    chk("busy", busy_o, 1'b1);
    @(posedge clk_i); #1;
    op_valid_i = 0;
    chk("refused", bank_select_reg_o, 6'h15);
  endtask
  initial begin
    repeat (3) @(posedge clk_i);
    #1 rst_n_i = 1;
    t_modes();
    t_rel();
    t_lit();
    t_ce();
    t_busy();
    end_of_test();
  end
endmodule // tb_top
